// file: include/adc_seq_consts.vh
// Constants for the converter channel sequencer: map, fields, resets, timing
// Overview of operation
// RL1 - Each measurement routes one of fourteen analog inputs through a sixteen-way selector.
// RL2 - Each result is a 14-bit two's-complement value; software scales it to 10 bits.
// RL3 - Three result buffers, one per channel, each hold until that channel's next result.
// RL4 - A measurement cycle converts channel 1, then channel 2, then channel 3.
// RL5 - When a channel's conversion finishes, its sample-valid flag is set.
// RL6 - The interrupt line is high when any enabled event among end-of-cycle and valids is set.
// RL7 - After selecting an input the block waits a programmable number of delay units.
// RL8 - The delay setting resets to a value meaning 256 delay units.
// RL9 - Conversion lasts about 3.6 ms with the low-pass filter on and 780 us with it off.
// RL10 - Firmware must program a suitable settling delay when changing a channel's input.
// RL11 - Reset leaves the converter off, interrupts masked, events clear, inputs disabled.
// RL12 - The converter clock is the system clock divided by the programmed divisor.
// RL13 - While the converter is enabled, the selected channels are measured continuously.
// RL14 - After channel 3 the cycle end is signalled and channel 1 follows; disabled ones skip. Code signals it only after a round that measured a channel.
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH

// Register indices; byte address is four times the index
`define REG_STATUS      6'h00
`define REG_CONFIG      6'h01
`define REG_CLKDIV      6'h02
`define REG_DELAY       6'h03
`define REG_CH1_CTL     6'h06
`define REG_CH1_LSB     6'h07
`define REG_CH1_MSB     6'h08
`define CH_STRIDE       6'h03

// Field positions
`define ST_CYCLE_END    0
`define CF_ENABLE       0
`define CF_LOWPASS      1
`define CF_END_IRQ_EN   2
`define CF_CH1_IRQ_EN   3
`define CC_VALID        7

// Reset values
`define SEL_DISABLED    4'hF
`define DELAY_RESET     8'hFF
`define DELAY_UNITS_DEF 256
`define SYS_CLK_HZ      200000000
`define CONV_CLK_HZ     500000
`define DIVISOR_RESET   (`SYS_CLK_HZ / `CONV_CLK_HZ)

`endif

// file: rtl/conv_clock_divider.v
// Divider producing the converter clock enable pulse
`timescale 1ns/100ps
module conv_clock_divider #(
    parameter WIDTH = 16
) (
    input  wire             clk_sys,
    input  wire             rst_n,
    input  wire             run,
    input  wire [WIDTH-1:0] divisor,
    output reg              tick
);
    reg [WIDTH-1:0] count_r;

    // Divisor of zero or one gives a tick every cycle
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= {WIDTH{1'b0}};
            tick    <= 1'b0;
        end else if (!run) begin
            count_r <= {WIDTH{1'b0}};
            tick    <= 1'b0;
        end else if (count_r + {{(WIDTH-1){1'b0}}, 1'b1} >= divisor) begin
            count_r <= {WIDTH{1'b0}};
            tick    <= 1'b1; // see RL12
        end else begin
            count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
            tick    <= 1'b0;
        end
    end
endmodule // conv_clock_divider

// file: rtl/adc_channel_sequencer.v
// Three-channel converter sequencer with an Avalon-MM register slave
`timescale 1ns/100ps
`include "adc_seq_consts.vh"
module adc_channel_sequencer #(
    parameter DIV_WIDTH = 16,
    parameter RES_WIDTH = 14
) (
    input  wire                 clk_sys,
    input  wire                 rst_n,
    input  wire [7:0]           address,
    input  wire                 read,
    input  wire                 write,
    input  wire [31:0]          writedata,
    input  wire [3:0]           byteenable,
    output reg  [31:0]          readdata,
    output reg                  waitrequest,
    output reg  [3:0]           input_select,
    output reg                  converter_on,
    output reg                  lowpass_filter_enable,
    output reg                  converter_clk_tick,
    output reg                  conv_start,
    input  wire                 conv_done,
    input  wire [RES_WIDTH-1:0] conv_result,
    output reg                  converter_irq_line
);
    localparam ST_IDLE    = 3'd0;
    localparam ST_SELECT  = 3'd1;
    localparam ST_SETTLE  = 3'd2;
    localparam ST_CONVERT = 3'd3;
    localparam ST_NEXT    = 3'd4;
    // Reset divisor is reckoned wide, then cut to the register width on purpose
    localparam [31:0] DIV_RESET_FULL = `DIVISOR_RESET;

    reg  [2:0]           state_r;
    reg  [1:0]           chan_r;
    reg  [8:0]           delay_left_r;
    reg                  measured_r;
    reg                  converter_enable_r;
    reg                  cycle_end_irq_enable_r;
    reg  [2:0]           valid_irq_enable_r;
    reg  [DIV_WIDTH-1:0] converter_clock_divisor_r;
    reg  [7:0]           select_delay_count_r;
    reg                  cycle_end_r;
    reg  [2:0]           sample_valid_flag_r;
    reg  [3:0]           chan_sel_r [0:2];
    reg  [RES_WIDTH-1:0] result_r [0:2];
    reg                  cycle_end_set;
    reg  [2:0]           valid_set;
    reg  [31:0]          rd_mux;
    wire                 div_tick;
    wire [5:0]           index = address[7:2];
    wire                 wr_take = write && !waitrequest;
    wire                 lane0 = wr_take && byteenable[0];
    genvar               g;

    conv_clock_divider #(
        .WIDTH   (DIV_WIDTH)
    ) u_div (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .run     (converter_enable_r),
        .divisor (converter_clock_divisor_r),
        .tick    (div_tick)
    );

    // Bus handshake: one wait cycle, then the answer for one cycle
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0000_0000;
        end else if ((read || write) && waitrequest) begin
            waitrequest <= 1'b0;
            readdata    <= read ? rd_mux : 32'h0000_0000;
        end else begin
            waitrequest <= 1'b1;
        end
    end

    // Read decode; unmapped words read as zero
    always @* begin
        rd_mux = 32'h0000_0000;
        case (index)
            `REG_STATUS: rd_mux[`ST_CYCLE_END] = cycle_end_r;
            `REG_CONFIG: rd_mux[5:0] = {valid_irq_enable_r, cycle_end_irq_enable_r,
                                        lowpass_filter_enable, converter_enable_r};
            `REG_CLKDIV: rd_mux[DIV_WIDTH-1:0] = converter_clock_divisor_r;
            `REG_DELAY:  rd_mux[7:0] = select_delay_count_r;
            `REG_CH1_CTL: rd_mux[7:0] = {sample_valid_flag_r[0], 3'b000, chan_sel_r[0]};
            `REG_CH1_LSB: rd_mux[7:0] = result_r[0][7:0];
            `REG_CH1_MSB: rd_mux[RES_WIDTH-9:0] = result_r[0][RES_WIDTH-1:8];
            `REG_CH1_CTL + `CH_STRIDE: rd_mux[7:0] = {sample_valid_flag_r[1], 3'b000,
                                                      chan_sel_r[1]};
            `REG_CH1_LSB + `CH_STRIDE: rd_mux[7:0] = result_r[1][7:0];
            `REG_CH1_MSB + `CH_STRIDE: rd_mux[RES_WIDTH-9:0] = result_r[1][RES_WIDTH-1:8];
            `REG_CH1_CTL + 2 * `CH_STRIDE: rd_mux[7:0] = {sample_valid_flag_r[2], 3'b000,
                                                          chan_sel_r[2]};
            `REG_CH1_LSB + 2 * `CH_STRIDE: rd_mux[7:0] = result_r[2][7:0];
            `REG_CH1_MSB + 2 * `CH_STRIDE: rd_mux[RES_WIDTH-9:0] =
                result_r[2][RES_WIDTH-1:8];
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Configuration registers
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            converter_enable_r        <= 1'b0; // see RL11
            lowpass_filter_enable     <= 1'b0;
            cycle_end_irq_enable_r    <= 1'b0; // see RL11
            valid_irq_enable_r        <= 3'b000;
            converter_clock_divisor_r <= DIV_RESET_FULL[DIV_WIDTH-1:0];
            select_delay_count_r      <= `DELAY_RESET; // see RL8
        end else begin
            if (lane0 && index == `REG_CONFIG) begin
                converter_enable_r     <= writedata[`CF_ENABLE];
                lowpass_filter_enable  <= writedata[`CF_LOWPASS]; // see RL9
                cycle_end_irq_enable_r <= writedata[`CF_END_IRQ_EN];
                valid_irq_enable_r     <= writedata[`CF_CH1_IRQ_EN+2:`CF_CH1_IRQ_EN];
            end
            if (lane0 && index == `REG_CLKDIV)
                converter_clock_divisor_r[7:0] <= writedata[7:0];
            if (wr_take && byteenable[1] && index == `REG_CLKDIV)
                converter_clock_divisor_r[DIV_WIDTH-1:8] <= writedata[DIV_WIDTH-1:8];
            if (lane0 && index == `REG_DELAY)
                select_delay_count_r <= writedata[7:0];
        end
    end

    // Cycle-end flag: hardware set wins over a write-one clear
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            cycle_end_r <= 1'b0;
        else if (cycle_end_set)
            cycle_end_r <= 1'b1; // see RL14
        else if (lane0 && index == `REG_STATUS && writedata[`ST_CYCLE_END])
            cycle_end_r <= 1'b0;
    end

    // Per-channel control, valid flag and result buffer
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_chan
            always @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    chan_sel_r[g]          <= `SEL_DISABLED; // see RL11
                    sample_valid_flag_r[g] <= 1'b0;
                    result_r[g]            <= {RES_WIDTH{1'b0}};
                end else begin
                    if (lane0 && index == `REG_CH1_CTL + g * `CH_STRIDE)
                        chan_sel_r[g] <= writedata[3:0];
                    if (valid_set[g])
                        sample_valid_flag_r[g] <= 1'b1; // see RL5
                    else if (lane0 && index == `REG_CH1_CTL + g * `CH_STRIDE &&
                             writedata[`CC_VALID])
                        sample_valid_flag_r[g] <= 1'b0;
                    // Buffer holds until this same channel converts again
                    if (valid_set[g])
                        result_r[g] <= conv_result; // see RL2, RL3
                end
            end
        end
    endgenerate

    // Event strobes from the sequencer
    always @* begin
        valid_set     = 3'b000;
        cycle_end_set = 1'b0;
        if (state_r == ST_CONVERT && conv_done && converter_enable_r)
            valid_set[chan_r] = 1'b1;
        if (state_r == ST_NEXT && chan_r == 2'd2 && measured_r)
            cycle_end_set = 1'b1;
    end

    // Sequencer: select, settle, convert, advance
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r      <= ST_IDLE;
            chan_r       <= 2'd0;
            delay_left_r <= 9'd0;
            measured_r   <= 1'b0;
            input_select <= `SEL_DISABLED;
            conv_start   <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            if (!converter_enable_r) begin
                // Disabling aborts any conversion in flight
                state_r      <= ST_IDLE;
                chan_r       <= 2'd0;
                measured_r   <= 1'b0;
                input_select <= `SEL_DISABLED;
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        chan_r  <= 2'd0; // see RL4
                        state_r <= ST_SELECT;
                    end
                    ST_SELECT: begin
                        if (chan_sel_r[chan_r] == `SEL_DISABLED) begin
                            state_r <= ST_NEXT; // see RL14
                        end else begin
                            input_select <= chan_sel_r[chan_r]; // see RL1
                            delay_left_r <= {1'b0, select_delay_count_r} + 9'd1;
                            state_r      <= ST_SETTLE;
                        end
                    end
                    ST_SETTLE: begin
                        if (div_tick) begin
                            if (delay_left_r == 9'd1) begin
                                conv_start <= 1'b1; // see RL7
                                state_r    <= ST_CONVERT;
                            end
                            delay_left_r <= delay_left_r - 9'd1;
                        end
                    end
                    ST_CONVERT: begin
                        if (conv_done) begin
                            measured_r <= 1'b1;
                            state_r    <= ST_NEXT;
                        end
                    end
                    ST_NEXT: begin
                        state_r <= ST_SELECT;
                        if (chan_r == 2'd2) begin
                            chan_r     <= 2'd0; // see RL13, RL14
                            measured_r <= 1'b0;
                        end else begin
                            chan_r <= chan_r + 2'd1; // see RL4
                        end
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end

    // Registered outputs toward the converter and interrupt controller
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            converter_on       <= 1'b0;
            converter_clk_tick <= 1'b0;
            converter_irq_line <= 1'b0;
        end else begin
            converter_on       <= converter_enable_r;
            converter_clk_tick <= div_tick; // see RL12
            converter_irq_line <= (cycle_end_r && cycle_end_irq_enable_r) ||
                                  |(sample_valid_flag_r & valid_irq_enable_r); // see RL6
        end
    end
endmodule // adc_channel_sequencer

// file: sim/adc_channel_sequencer_sva.sv
// Port-level assertions for the converter channel sequencer
`timescale 1ns/100ps
module adc_seq_checker (
    input wire       clk_sys,
    input wire       rst_n,
    input wire       read,
    input wire       write,
    input wire       waitrequest,
    input wire [3:0] input_select,
    input wire       converter_on,
    input wire       converter_clk_tick,
    input wire       conv_start,
    input wire       conv_done,
    input wire       converter_irq_line
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // A taken request sees exactly one low waitrequest cycle
    sequence s_take; (read || write) && waitrequest; endsequence
    sequence s_answer; !waitrequest ##1 waitrequest; endsequence
    property p_answer; s_take |=> s_answer; endproperty
    a_answer: assert property (p_answer) else $error("bus answer not one cycle");
    property p_idle; !read && !write && waitrequest |=> waitrequest; endproperty
    a_idle: assert property (p_idle) else $error("answer with no request");
    // Margin of three covers the late enable mirror
    property p_off; !converter_on [*3] |-> input_select == 4'hF && !conv_start; endproperty
    a_off: assert property (p_off) else $error("selector busy while off");
    property p_sel; conv_start |-> input_select != 4'hF && $stable(input_select); endproperty
    a_sel: assert property (p_sel) else $error("start on bad input");
    // Abort parks the selector, so a change to Fh is allowed mid conversion
    sequence s_busy; !conv_start && ($stable(input_select) || input_select == 4'hF); endsequence
    property p_one; conv_start |=> s_busy [*6]; endproperty
    a_one: assert property (p_one) else $error("second start too soon");
    property p_tick; converter_clk_tick |-> converter_on || $past(converter_on); endproperty
    a_tick: assert property (p_tick) else $error("tick while off");
    // Interrupt moves two edges after a result or an accepted write
    // Cycle end trails the last result by one, three or five more edges when channels skip
    property p_rise; $rose(converter_irq_line) |->
        $past(conv_done, 2) || $past(conv_done, 3) || $past(conv_done, 5) ||
        $past(conv_done, 7) || ($past(write, 2) && !$past(waitrequest, 2)); endproperty
    a_rise: assert property (p_rise) else $error("irq rose without cause");
    property p_fall; $fell(converter_irq_line) |-> $past(write, 2) && !$past(waitrequest, 2);
    endproperty
    a_fall: assert property (p_fall) else $error("irq fell without write");
endmodule // adc_seq_checker

bind adc_channel_sequencer adc_seq_checker u_chk (.clk_sys, .rst_n, .read, .write,
    .waitrequest, .input_select, .converter_on, .converter_clk_tick, .conv_start,
    .conv_done, .converter_irq_line);

// file: sim/conv_core_model.sv
// Behavioural converter core answering start pulses
`timescale 1ns/100ps
module conv_core_model #(
    parameter FAST = 9,
    parameter SLOW = 20
) (
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire        conv_start,
    input  wire        lowpass_filter_enable,
    input  wire [3:0]  input_select,
    output reg         conv_done,
    output reg  [13:0] conv_result
);
    integer cnt_r;
    // Filtered conversions run longer; result tags the selected input
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r       <= 0;
            conv_done   <= 1'b0;
            conv_result <= 14'h0000;
        end else begin
            conv_done <= (cnt_r == 1);
            // Data is only valid with done; toggling elsewhere exposes a late capture
            conv_result <= (cnt_r == 1) ? {input_select, 10'h3A5} : ~conv_result;
            if (conv_start)
                cnt_r <= lowpass_filter_enable ? SLOW : FAST;
            else if (cnt_r != 0)
                cnt_r <= cnt_r - 1;
        end
    end
endmodule // conv_core_model

// file: sim/test_adc_channel_sequencer.sv
// Self-checking bench for the converter channel sequencer
`timescale 1ns/100ps
`include "adc_seq_consts.vh"
module test_adc_channel_sequencer;
    reg         clk_sys = 1'b0;
    reg         rst_n = 1'b0;
    reg         read = 1'b0;
    reg         write = 1'b0;
    reg  [7:0]  address = 8'h00;
    reg  [31:0] writedata = 32'h0000_0000;
    reg  [3:0]  byteenable = 4'hF;
    wire [31:0] readdata;
    wire        waitrequest, converter_on, lowpass_filter_enable, converter_clk_tick;
    wire        conv_start, conv_done, converter_irq_line;
    wire [3:0]  input_select;
    wire [13:0] conv_result;
    reg  [31:0] rd;
    reg  [13:0] res;
    integer     error_cnt = 0;
    integer     compares = 0;
    integer     c0, c1, i;

    adc_channel_sequencer dut (.clk_sys, .rst_n, .address, .read, .write, .writedata,
        .byteenable, .readdata, .waitrequest, .input_select, .converter_on,
        .lowpass_filter_enable, .converter_clk_tick, .conv_start, .conv_done, .conv_result,
        .converter_irq_line);
    conv_core_model u_conv (.clk_sys, .rst_n, .conv_start, .lowpass_filter_enable,
        .input_select, .conv_done, .conv_result);

    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    task chk(input [31:0] got, input [31:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("mismatch at %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    // One access, held until waitrequest is sampled low
    task bus(input wr, input [5:0] idx, input [31:0] d);
        begin
            @(posedge clk_sys);
            address   <= {idx, 2'b00};
            writedata <= d;
            write     <= wr;
            read      <= !wr;
            @(posedge clk_sys);
            while (waitrequest !== 1'b0) @(posedge clk_sys);
            rd = readdata;
            write <= 1'b0;
            read  <= 1'b0;
        end
    endtask

    // Edges up to the next tick (sel) or start pulse
    task wait_ev(input sel, output integer n);
        begin
            n = 0;
            do begin
                @(posedge clk_sys);
                n = n + 1;
            end while ((sel ? converter_clk_tick : conv_start) !== 1'b1);
        end
    endtask

    task t_reset;
        begin
            chk(input_select, 4'hF);
            bus(0, `REG_CONFIG, 0);
            chk(rd, 0);
            bus(0, `REG_CLKDIV, 0);
            chk(rd, `DIVISOR_RESET);
            byteenable <= 4'h0;
            bus(1, `REG_DELAY, 32'h0000_0003);
            byteenable <= 4'hF;
            bus(0, `REG_DELAY, 0);
            chk(rd, `DELAY_RESET);
            bus(0, 6'h04, 0);
            chk(rd, 0);
            for (i = 0; i < 3; i = i + 1) begin
                bus(0, 6'(`REG_CH1_CTL + `CH_STRIDE * i), 0);
                chk(rd, `SEL_DISABLED);
            end
        end
    endtask

    // Divisor 1: each delay unit adds one cycle; ch2 and ch3 off are skipped
    task t_delay;
        begin
            bus(1, `REG_CLKDIV, 32'h0000_0001);
            bus(1, `REG_CH1_CTL, 32'h0000_0009);
            bus(1, `REG_DELAY, 32'h0000_0000);
            bus(1, `REG_CONFIG, 32'h0000_0001);
            wait_ev(0, c0);
            bus(1, `REG_CONFIG, 32'h0000_0000);
            bus(1, `REG_DELAY, 32'h0000_0003);
            bus(1, `REG_CONFIG, 32'h0000_0003);
            wait_ev(0, c1);
            chk(c1 - c0, 3);
            chk(lowpass_filter_enable, 1'b1);
            wait_ev(0, c0);
            chk(input_select, 4'h9);
            chk(c0 >= 20, 1);
            bus(1, `REG_CONFIG, 32'h0000_0000);
        end
    endtask

    task t_tick;
        begin
            bus(1, `REG_CLKDIV, 32'h0000_0003);
            bus(1, `REG_CONFIG, 32'h0000_0001);
            wait_ev(1, c0);
            wait_ev(1, c0);
            chk(c0, 3);
            chk(converter_on, 1'b1);
            bus(1, `REG_CONFIG, 32'h0000_0000);
        end
    endtask

    // Rounds over codes 4, 7, A with all events enabled, then readback and masking
    task t_cycle;
        begin
            bus(1, `REG_CLKDIV, 32'h0000_0002);
            bus(1, `REG_DELAY, 32'h0000_0001);
            for (i = 0; i < 3; i = i + 1)
                bus(1, 6'(`REG_CH1_CTL + `CH_STRIDE * i), 4 + 3 * i);
            bus(1, `REG_CONFIG, 32'h0000_003D);
            for (i = 0; i < 4; i = i + 1) begin
                wait_ev(0, c0);
                chk(input_select, 4 + 3 * (i % 3));
            end
            bus(1, `REG_CONFIG, 32'h0000_003C);
            chk(converter_irq_line, 1'b1);
            for (i = 0; i < 3; i = i + 1) begin
                res = {4'(4 + 3 * i), 10'h3A5};
                bus(0, 6'(`REG_CH1_LSB + `CH_STRIDE * i), 0);
                chk(rd, res[7:0]);
                bus(0, 6'(`REG_CH1_MSB + `CH_STRIDE * i), 0);
                chk(rd, res[13:8]);
                bus(0, 6'(`REG_CH1_CTL + `CH_STRIDE * i), 0);
                chk(rd, 32'h0000_0080 | (4 + 3 * i));
            end
            bus(0, `REG_STATUS, 0);
            chk(rd, 32'h0000_0001);
            bus(1, `REG_CONFIG, 32'h0000_0000);
            repeat (2) @(posedge clk_sys);
            chk(converter_irq_line, 1'b0);
            bus(1, `REG_STATUS, 32'h0000_0001);
            bus(0, `REG_STATUS, 0);
            chk(rd, 0);
            // Write-one clear of the valid flag keeps the select code
            bus(1, `REG_CH1_CTL, 32'h0000_0084);
            bus(0, `REG_CH1_CTL, 0);
            chk(rd, 32'h0000_0004);
        end
    endtask

    task final_report;
        begin
            $display("errors %0d compares %0d", error_cnt, compares);
            if (error_cnt == 0 && compares > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset;
        t_delay;
        t_tick;
        t_cycle;
        final_report;
    end

    // Watchdog: whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt = error_cnt + 1;
        final_report;
    end
endmodule // test_adc_channel_sequencer
